// File: i2cta_bus_model.sv
// Far-side bus master: START, address bytes at 125 ns per bit, STOP.
// Assumes pull-up wires resolved by the bench; clock idle high.
`timescale 1ns/1ps
`default_nettype none
module i2cta_bus_model (
   input  wire logic sda_in,
   output logic      scl_out,
   output logic      sda_out
);
   initial begin
      scl_out = 1'b1;
      sda_out = 1'b1;
   end
   // Bit j of ak set when byte j was acknowledged
   task automatic frame(input logic [15:0] w, input int nb,
                        output logic [1:0] ak);
      ak = 2'b00;
      sda_out = 1'b0;
      #125 scl_out = 1'b0;
      for (int j = 0; j < nb; j++) begin
         for (int i = 0; i < 9; i++) begin
            #30 sda_out = (i < 8) ? w[15 - 8 * j - i] : 1'b1;
            #32 scl_out = 1'b1;
            if (i == 8) ak[j] = !sda_in;
            #63 scl_out = 1'b0;
         end
      end
      #30 sda_out = 1'b0;
      #32 scl_out = 1'b1;
      #30 sda_out = 1'b1;
   endtask
endmodule // i2cta_bus_model
`default_nettype wire

// File: i2cta_defs.svh
// Constants of the timeout and own-address block: offsets, fields, resets
// and timing counts. Assumes a 125 MHz system clock.
//
// Overview of operation
// - Timeout register resets to zero, freely accessible
// - Timeout acts only in master mode
// - Timeout value counts bit periods awaiting SCL high
// - Counter restarts on start request and SCL fall
// - Zero timeout value disables the timeout
// - Expired counter without SCL rise sets timeout flag
// - Interval is bit period times value plus one
// - Own address register resets to zero, freely accessible
// - Low ten bits hold own address for compare
// - Enabled match acknowledges with configured acknowledge level
// - Match sets flag, clears master bit, interrupts
// - Own address bits fifteen to ten read zero
// - Timeout clears start request and interrupts
`ifndef I2CTA_DEFS_SVH
`define I2CTA_DEFS_SVH

// Register indexes; byte address is four times the index
`define I2CTA_IDX_TIMEOUT 8'h0e
`define I2CTA_IDX_OWN     8'h0f
`define I2CTA_IDX_CTRL    8'h10
`define I2CTA_IDX_STAT    8'h11
`define I2CTA_IDX_MASK    8'h12

// Control fields
`define I2CTA_CTRL_EN     0
`define I2CTA_CTRL_MST    1
`define I2CTA_CTRL_START  2
`define I2CTA_CTRL_ACKV   3

// Status and mask fields
`define I2CTA_ST_TO       0
`define I2CTA_ST_AM       1

// Reset values
`define I2CTA_TIMEOUT_RST 8'h00
`define I2CTA_OWN_RST     10'h000
`define I2CTA_CTRL_RST    1'b0

// Ten-bit address header pattern
`define I2CTA_TEN_HDR     5'h1e

// AXI responses
`define I2CTA_RESP_OKAY   2'h0
`define I2CTA_RESP_SLVERR 2'h2

// Timing: one bit period in ns and in system clocks
`define I2CTA_CLK_NS      8
`define I2CTA_BIT_NS      10000
`define I2CTA_BIT_CYC ((`I2CTA_BIT_NS + `I2CTA_CLK_NS - 1) / `I2CTA_CLK_NS)

`endif

// File: i2cta_pkg.sv
// Types of the timeout and own-address block.
// Assumes i2cta_defs.svh is compiled alongside.
package i2cta_pkg;

   typedef enum logic [4:0] {
      I2CTA_IDLE  = 5'h01,
      I2CTA_BYTE1 = 5'h02,
      I2CTA_BYTE2 = 5'h04,
      I2CTA_ACK   = 5'h08,
      I2CTA_WAIT  = 5'h10
   } i2cta_slv_t;

   typedef struct packed {
      logic [1:0] stage1;
      logic [1:0] stage2;
   } i2cta_sync_st_t;

   typedef struct packed {
      logic [10:0] cnt;
      logic        tick;
   } i2cta_tick_st_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic        aw_got;
      logic [7:0]  aw_idx;
      logic        w_got;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic [7:0]  timeout;
      logic [9:0]  own;
      logic        enable;
      logic        master;
      logic        start;
      logic        ackv;
      logic [1:0]  stat;
      logic [1:0]  mask;
      logic        irq;
      logic        scl_prev;
      logic        sda_prev;
      logic        to_armed;
      logic [7:0]  to_cnt;
      i2cta_slv_t  slv;
      logic [3:0]  bit_cnt;
      logic [7:0]  shreg;
      logic        ten_pend;
      logic        sda_oe;
      logic        sda_out;
   } i2cta_top_st_t;

endpackage

// File: i2cta_props.sv
// Checker of the timeout and own-address block at its top ports.
// Assumes binding to i2cta_top; sees ports only.
`timescale 1ns/1ps
`default_nettype none
module i2cta_props (
   input wire logic        ref_clk_in,
   input wire logic        rst_n_in,
   input wire logic        s_axi_awvalid_in,
   input wire logic        s_axi_awready_out,
   input wire logic        s_axi_wvalid_in,
   input wire logic        s_axi_wready_out,
   input wire logic        s_axi_bvalid_out,
   input wire logic [1:0]  s_axi_bresp_out,
   input wire logic        s_axi_bready_in,
   input wire logic        s_axi_arvalid_in,
   input wire logic        s_axi_arready_out,
   input wire logic        s_axi_rvalid_out,
   input wire logic [31:0] s_axi_rdata_out,
   input wire logic        s_axi_rready_in,
   input wire logic        scl_in,
   input wire logic        sda_oe_out,
   input wire logic        irq_out,
   input wire logic        master_mode_out,
   input wire logic        start_request_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);
   //////////////////////////////
   bvalid_hold_a: assert property (
      s_axi_bvalid_out && !s_axi_bready_in |=>
      s_axi_bvalid_out && $stable(s_axi_bresp_out))
      else $error("write response dropped early");
   rvalid_hold_a: assert property (
      s_axi_rvalid_out && !s_axi_rready_in |=>
      s_axi_rvalid_out && $stable(s_axi_rdata_out))
      else $error("read data dropped early");
   ar_block_a: assert property (
      s_axi_rvalid_out |-> !s_axi_arready_out)
      else $error("read address taken while data pending");
   rd_answer_a: assert property (
      s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
      else $error("read not answered next cycle");
   wr_answer_a: assert property (
      s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in &&
      s_axi_wready_out |-> ##2 s_axi_bvalid_out)
      else $error("write not answered in time");
   ack_phase_a: assert property (
      $rose(sda_oe_out) |-> !scl_in)
      else $error("acknowledge driven while clock high");
   start_master_a: assert property (
      !master_mode_out && !$past(master_mode_out) |-> !start_request_out)
      else $error("start request outside master mode");
   irq_sticky_a: assert property (
      $fell(irq_out) |-> s_axi_bvalid_out)
      else $error("interrupt fell without a register write");
endmodule // i2cta_props

bind i2cta_top i2cta_props i_i2cta_props (.ref_clk_in, .rst_n_in,
   .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wvalid_in,
   .s_axi_wready_out, .s_axi_bvalid_out, .s_axi_bresp_out,
   .s_axi_bready_in, .s_axi_arvalid_in, .s_axi_arready_out,
   .s_axi_rvalid_out, .s_axi_rdata_out, .s_axi_rready_in, .scl_in,
   .sda_oe_out, .irq_out, .master_mode_out, .start_request_out);
`default_nettype wire

// File: i2cta_sync.sv
// Two-flop synchroniser for the SCL and SDA pin levels.
// Assumes pins are asynchronous to ref_clk_in.
`timescale 1ns/1ps
`default_nettype none
module i2cta_sync (
   input  wire logic       ref_clk_in,
   input  wire logic       rst_n_in,
   input  wire logic [1:0] pins_in,
   output logic      [1:0] pins_out
);
   i2cta_pkg::i2cta_sync_st_t q;
   i2cta_pkg::i2cta_sync_st_t d;

   always_comb begin
      d        = q;
      d.stage1 = pins_in;
      d.stage2 = q.stage1;
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         q <= '{stage1: 2'h3, stage2: 2'h3};
      end else begin
         q <= d;
      end
   end

   assign pins_out = q.stage2;
endmodule // i2cta_sync
`default_nettype wire

// File: i2cta_tick.sv
// Bit-period divider: one-cycle enable pulse every bit period while run.
// Assumes clr_in and run_in come from logic on ref_clk_in.
`timescale 1ns/1ps
`include "i2cta_defs.svh"
`default_nettype none
module i2cta_tick (
   input  wire logic ref_clk_in,
   input  wire logic rst_n_in,
   input  wire logic clr_in,
   input  wire logic run_in,
   output logic      tick_out
);
   i2cta_pkg::i2cta_tick_st_t q;
   i2cta_pkg::i2cta_tick_st_t d;

   always_comb begin
      d      = q;
      d.tick = 1'b0;
      if (clr_in || !run_in) begin
         d.cnt = 11'h000;
      end else if (q.cnt == 11'(`I2CTA_BIT_CYC - 1)) begin
         d.cnt  = 11'h000;
         d.tick = 1'b1;
      end else begin
         d.cnt = q.cnt + 11'h001;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         q <= '{cnt: 11'h000, tick: 1'b0};
      end else begin
         q <= d;
      end
   end

   assign tick_out = q.tick;
endmodule // i2cta_tick
`default_nettype wire

// File: i2cta_top.sv
// Master SCL timeout counter and own-address match with AXI4-Lite registers.
// Assumes SCL/SDA are open-drain pins resolved outside; AXI on ref_clk_in.
`timescale 1ns/1ps
`include "i2cta_defs.svh"
`default_nettype none
module i2cta_top (
   input  wire logic        ref_clk_in,
   input  wire logic        rst_n_in,
   input  wire logic [11:0] s_axi_awaddr_in,
   input  wire logic        s_axi_awvalid_in,
   output logic             s_axi_awready_out,
   input  wire logic [31:0] s_axi_wdata_in,
   input  wire logic [3:0]  s_axi_wstrb_in,
   input  wire logic        s_axi_wvalid_in,
   output logic             s_axi_wready_out,
   output logic [1:0]       s_axi_bresp_out,
   output logic             s_axi_bvalid_out,
   input  wire logic        s_axi_bready_in,
   input  wire logic [11:0] s_axi_araddr_in,
   input  wire logic        s_axi_arvalid_in,
   output logic             s_axi_arready_out,
   output logic [31:0]      s_axi_rdata_out,
   output logic [1:0]       s_axi_rresp_out,
   output logic             s_axi_rvalid_out,
   input  wire logic        s_axi_rready_in,
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe_out,
   output logic             irq_out,
   output logic             master_mode_out,
   output logic             start_request_out
);
   i2cta_pkg::i2cta_top_st_t q;
   i2cta_pkg::i2cta_top_st_t d;

   logic [1:0] pins_s;
   logic       tick;
   logic       to_clr;
   logic       scl_s;
   logic       sda_s;
   logic       scl_rise;
   logic       scl_fall;
   logic       start_cond;
   logic       stop_cond;

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic logic [7:0] i2cta_idx(input logic [11:0] addr);
      i2cta_idx = addr[9:2];
   endfunction

   // Returns {error, data}
   function automatic logic [32:0] i2cta_rd(
      input logic [7:0]                idx,
      input i2cta_pkg::i2cta_top_st_t  s
   );
      i2cta_rd = 33'h000000000;
      case (idx)
         `I2CTA_IDX_TIMEOUT: i2cta_rd[7:0] = s.timeout;
         `I2CTA_IDX_OWN:     i2cta_rd[9:0] = s.own;
         `I2CTA_IDX_CTRL: begin
            i2cta_rd[`I2CTA_CTRL_EN]    = s.enable;
            i2cta_rd[`I2CTA_CTRL_MST]   = s.master;
            i2cta_rd[`I2CTA_CTRL_START] = s.start;
            i2cta_rd[`I2CTA_CTRL_ACKV]  = s.ackv;
         end
         `I2CTA_IDX_STAT:    i2cta_rd[1:0] = s.stat;
         `I2CTA_IDX_MASK:    i2cta_rd[1:0] = s.mask;
         default:            i2cta_rd[32]  = 1'b1;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Pin synchroniser and bit-period divider

   i2cta_sync u_sync (
      .ref_clk_in (ref_clk_in),
      .rst_n_in   (rst_n_in),
      .pins_in    ({scl_in, sda_in}),
      .pins_out   (pins_s)
   );

   i2cta_tick u_tick (
      .ref_clk_in (ref_clk_in),
      .rst_n_in   (rst_n_in),
      .clr_in     (to_clr),
      .run_in     (q.to_armed),
      .tick_out   (tick)
   );

   assign scl_s      = pins_s[1];
   assign sda_s      = pins_s[0];
   assign scl_rise   = scl_s & ~q.scl_prev;
   assign scl_fall   = ~scl_s & q.scl_prev;
   assign start_cond = scl_s & q.scl_prev & q.sda_prev & ~sda_s;
   assign stop_cond  = scl_s & q.scl_prev & ~q.sda_prev & sda_s;

   ////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      logic [32:0] rd;
      logic        do_wr;
      logic        start_set;
      logic        match;
      logic        to_active;
      rd        = 33'h000000000;
      do_wr     = 1'b0;
      start_set = 1'b0;
      match     = 1'b0;
      to_active = 1'b0;
      to_clr    = 1'b0;
      d         = q;

      // Write address and data, taken in either order
      if (s_axi_awvalid_in && q.awready) begin
         d.aw_got = 1'b1;
         d.aw_idx = i2cta_idx(s_axi_awaddr_in);
      end
      if (s_axi_wvalid_in && q.wready) begin
         d.w_got = 1'b1;
         d.wdata = s_axi_wdata_in;
         d.wstrb = s_axi_wstrb_in;
      end
      if (q.bvalid && s_axi_bready_in) begin
         d.bvalid = 1'b0;
      end
      if (q.aw_got && q.w_got && !q.bvalid) begin
         do_wr    = 1'b1;
         d.aw_got = 1'b0;
         d.w_got  = 1'b0;
         d.bvalid = 1'b1;
         d.bresp  = `I2CTA_RESP_OKAY;
      end
      d.awready = ~d.aw_got & ~d.bvalid;
      d.wready  = ~d.w_got & ~d.bvalid;

      // Read channel
      if (q.rvalid && s_axi_rready_in) begin
         d.rvalid = 1'b0;
      end
      if (s_axi_arvalid_in && q.arready) begin
         rd       = i2cta_rd(i2cta_idx(s_axi_araddr_in), q);
         d.rvalid = 1'b1;
         d.rdata  = rd[31:0];
         d.rresp  = rd[32] ? `I2CTA_RESP_SLVERR : `I2CTA_RESP_OKAY;
      end
      d.arready = ~d.rvalid;

      // Register writes
      if (do_wr) begin
         case (q.aw_idx)
            `I2CTA_IDX_TIMEOUT: begin
               if (q.wstrb[0]) d.timeout = q.wdata[7:0];
            end
            `I2CTA_IDX_OWN: begin
               if (q.wstrb[0]) d.own[7:0] = q.wdata[7:0];
               if (q.wstrb[1]) d.own[9:8] = q.wdata[9:8];
            end
            `I2CTA_IDX_CTRL: begin
               if (q.wstrb[0]) begin
                  d.enable  = q.wdata[`I2CTA_CTRL_EN];
                  d.master  = q.wdata[`I2CTA_CTRL_MST];
                  d.start   = q.wdata[`I2CTA_CTRL_START];
                  d.ackv    = q.wdata[`I2CTA_CTRL_ACKV];
                  start_set = q.wdata[`I2CTA_CTRL_START];
               end
            end
            `I2CTA_IDX_STAT: begin
               if (q.wstrb[0]) d.stat = q.stat & ~q.wdata[1:0];
            end
            `I2CTA_IDX_MASK: begin
               if (q.wstrb[0]) d.mask = q.wdata[1:0];
            end
            default: d.bresp = `I2CTA_RESP_SLVERR;
         endcase
      end

      // Own-address receiver, after writes so hardware events win
      d.scl_prev = scl_s;
      d.sda_prev = sda_s;
      if (!q.enable) begin
         d.slv    = i2cta_pkg::I2CTA_IDLE;
         d.sda_oe = 1'b0;
      end else if (start_cond) begin
         d.slv      = i2cta_pkg::I2CTA_BYTE1;
         d.bit_cnt  = 4'h0;
         d.ten_pend = 1'b0;
         d.sda_oe   = 1'b0;
      end else if (stop_cond) begin
         d.slv    = i2cta_pkg::I2CTA_IDLE;
         d.sda_oe = 1'b0;
      end else begin
         case (q.slv)
            i2cta_pkg::I2CTA_IDLE: begin
               d.sda_oe = 1'b0;
            end
            i2cta_pkg::I2CTA_BYTE1, i2cta_pkg::I2CTA_BYTE2: begin
               if (scl_rise && q.bit_cnt != 4'h8) begin
                  d.shreg   = {q.shreg[6:0], sda_s};
                  d.bit_cnt = q.bit_cnt + 4'h1;
               end else if (scl_fall && q.bit_cnt == 4'h8) begin
                  d.slv = i2cta_pkg::I2CTA_WAIT;
                  if (q.slv == i2cta_pkg::I2CTA_BYTE2) begin
                     match = (q.shreg == q.own[7:0]);
                  end else if (q.shreg[7:3] == `I2CTA_TEN_HDR) begin
                     d.ten_pend = (q.shreg[2:1] == q.own[9:8]);
                  end else begin
                     match = (q.shreg[7:1] == q.own[6:0]);
                  end
                  if (match || d.ten_pend) begin
                     d.slv     = i2cta_pkg::I2CTA_ACK;
                     d.sda_oe  = ~q.ackv;
                     d.sda_out = 1'b0;
                  end
               end
            end
            i2cta_pkg::I2CTA_ACK: begin
               if (scl_fall) begin
                  d.sda_oe   = 1'b0;
                  d.bit_cnt  = 4'h0;
                  d.ten_pend = 1'b0;
                  d.slv      = q.ten_pend ? i2cta_pkg::I2CTA_BYTE2
                                          : i2cta_pkg::I2CTA_WAIT;
               end
            end
            i2cta_pkg::I2CTA_WAIT: begin
               d.sda_oe = 1'b0;
            end
            default: begin
               d.slv    = i2cta_pkg::I2CTA_IDLE;
               d.sda_oe = 1'b0;
            end
         endcase
      end
      if (match) begin
         d.stat[`I2CTA_ST_AM] = 1'b1;
         d.master             = 1'b0;
      end

      // Start request only lives in enabled master mode
      if (!d.master || !d.enable) begin
         d.start = 1'b0;
      end

      // Master SCL timeout
      to_active = d.master & d.enable & (q.timeout != 8'h00);
      if (!to_active) begin
         d.to_armed = 1'b0;
         d.to_cnt   = 8'h00;
      end else if ((start_set && d.start) || scl_fall) begin
         to_clr     = 1'b1;
         d.to_armed = 1'b1;
         d.to_cnt   = 8'h00;
      end else if (scl_rise) begin
         d.to_armed = 1'b0;
      end else if (q.to_armed && tick) begin
         if (q.to_cnt == q.timeout) begin
            d.to_armed           = 1'b0;
            d.stat[`I2CTA_ST_TO] = 1'b1;
            d.start              = 1'b0;
         end else begin
            d.to_cnt = q.to_cnt + 8'h01;
         end
      end

      d.irq = |(d.stat & d.mask);
   end

   ////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         q          <= '0;
         q.timeout  <= `I2CTA_TIMEOUT_RST;
         q.own      <= `I2CTA_OWN_RST;
         q.enable   <= `I2CTA_CTRL_RST;
         q.master   <= `I2CTA_CTRL_RST;
         q.start    <= `I2CTA_CTRL_RST;
         q.ackv     <= `I2CTA_CTRL_RST;
         q.scl_prev <= 1'b1;
         q.sda_prev <= 1'b1;
         q.slv      <= i2cta_pkg::I2CTA_IDLE;
      end else begin
         q <= d;
      end
   end

   assign s_axi_awready_out = q.awready;
   assign s_axi_wready_out  = q.wready;
   assign s_axi_bresp_out   = q.bresp;
   assign s_axi_bvalid_out  = q.bvalid;
   assign s_axi_arready_out = q.arready;
   assign s_axi_rdata_out   = q.rdata;
   assign s_axi_rresp_out   = q.rresp;
   assign s_axi_rvalid_out  = q.rvalid;
   assign sda_out           = q.sda_out;
   assign sda_oe_out        = q.sda_oe;
   assign irq_out           = q.irq;
   assign master_mode_out   = q.master;
   assign start_request_out = q.start;
endmodule // i2cta_top
`default_nettype wire

// File: test_i2c_timeout_and_slave_address.sv
// Bench of the timeout and own-address block against inline expectations.
// Assumes i2cta_bus_model as far side; checker arrives by bind.
`timescale 1ns/1ps
`default_nettype none
module test_i2c_timeout_and_slave_address;
   logic        clk, rst_n, awv, wv, bre, arv, rre, scl_rel;
   logic        awr, wrr, bv, arr, rv, sda_o, sda_oe, irq, mst, strt;
   logic [11:0] awa, ara;
   logic [31:0] wd, rd_o, rdv;
   logic [3:0]  ws;
   logic [1:0]  br, rr, rsp;
   wire  logic  m_scl, m_sda, scl_w, sda_w;
   int          error_cnt, n_compared;
   assign scl_w = m_scl & scl_rel;
   assign sda_w = m_sda & ~(sda_oe & ~sda_o);

   i2cta_top i_i2cta_top (.ref_clk_in(clk), .rst_n_in(rst_n),
      .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv),
      .s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(ws),
      .s_axi_wvalid_in(wv), .s_axi_wready_out(wrr), .s_axi_bresp_out(br),
      .s_axi_bvalid_out(bv), .s_axi_bready_in(bre),
      .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv),
      .s_axi_arready_out(arr), .s_axi_rdata_out(rd_o),
      .s_axi_rresp_out(rr), .s_axi_rvalid_out(rv), .s_axi_rready_in(rre),
      .scl_in(scl_w), .sda_in(sda_w), .sda_out(sda_o),
      .sda_oe_out(sda_oe), .irq_out(irq), .master_mode_out(mst),
      .start_request_out(strt));
   i2cta_bus_model i_i2cta_bus_model (.sda_in(sda_w), .scl_out(m_scl),
      .sda_out(m_sda));
   //////////////////////////////
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e) begin
         error_cnt++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic final_report();
      $display("compared=%0d errors=%0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      int n;
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bre <= 1'($urandom);
      for (n = 0; n < 40; n++) begin
         @(posedge clk);
         if (awr) awv <= 1'b0;
         if (wrr) wv <= 1'b0;
         if (bv && bre) break;
         if (bv) bre <= 1'b1;
      end
      rsp = br;
      if (n == 40) begin
         error_cnt++;
         final_report();
      end
   endtask
   task automatic rd(input logic [11:0] a);
      int n;
      ara <= a;
      arv <= 1'b1;
      rre <= 1'($urandom);
      for (n = 0; n < 40; n++) begin
         @(posedge clk);
         if (arr) arv <= 1'b0;
         if (rv && rre) break;
         if (rv) rre <= 1'b1;
      end
      rdv = rd_o;
      rsp = rr;
      if (n == 40) begin
         error_cnt++;
         final_report();
      end
   endtask
   //////////////////////////////
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      logic [9:0]  own;
      logic [31:0] d;
      logic [3:0]  cs [5];
      logic [3:0]  c;
      logic [15:0] fw;
      logic [1:0]  ak, ea;
      logic        m;
      int          n;
      int          exp_q [$];
      // Case bits: enable, ack level, ten-bit, wrong address
      cs = '{4'b1000, 4'b1001, 4'b0000, 4'b1010, 4'b1100};
      {awv, wv, arv, bre, rre, scl_rel, rst_n} = 7'b0001110;
      awa = 12'h000;
      ara = 12'h000;
      wd = 32'h0;
      ws = 4'hf;
      error_cnt = 0;
      n_compared = 0;
      void'($urandom(32'h2ab617b7));
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      rd(12'h038);
      chk(rdv, 32'h0);
      rd(12'h03c);
      chk(rdv, 32'h0);
      rd(12'h04c);
      chk(rsp, 32'h2);
      wr(12'h04c, 32'h1);
      chk(rsp, 32'h2);
      for (n = 0; n < 4; n++) begin
         d = $urandom;
         exp_q.push_back({24'h0, d[7:0]});
         exp_q.push_back({22'h0, ~d[9:0]});
         wr(12'h038, d);
         chk(rsp, 32'h0);
         rd(12'h038);
         chk(rdv, exp_q.pop_front());
         wr(12'h03c, ~d);
         rd(12'h03c);
         chk(rdv, exp_q.pop_front());
      end
      // Clock held low: no flag with zero limit or outside master mode
      scl_rel <= 1'b0;
      wr(12'h048, 32'h3);
      for (n = 0; n < 2; n++) begin
         wr(12'h038, n);
         wr(12'h040, n ? 32'h5 : 32'h7);
         repeat (3000) @(posedge clk);
         rd(12'h044);
         chk(rdv, 32'h0);
      end
      wr(12'h040, 32'h7);
      repeat (2000) @(posedge clk);
      chk(irq, 32'h0);
      chk(strt, 32'h1);
      scl_rel <= 1'b1;
      repeat (20) @(posedge clk);
      scl_rel <= 1'b0;
      for (n = 0; n < 4000 && irq !== 1'b1; n++) @(posedge clk);
      chk(n >= 2500 && n <= 2512, 32'h1);
      chk(strt, 32'h0);
      repeat (200) @(posedge clk);
      rd(12'h044);
      chk(rdv, 32'h1);
      wr(12'h048, 32'h2);
      repeat (2) @(posedge clk);
      chk(irq, 32'h0);
      wr(12'h048, 32'h3);
      repeat (2) @(posedge clk);
      chk(irq, 32'h1);
      wr(12'h044, 32'h1);
      repeat (2) @(posedge clk);
      chk(irq, 32'h0);
      // Address frames from the far-side master
      scl_rel <= 1'b1;
      wr(12'h038, 32'h0);
      own = 10'($urandom);
      own[6] = 1'b0;
      wr(12'h03c, {22'h0, own});
      foreach (cs[k]) begin
         c = cs[k];
         m = c[3] && !c[0];
         wr(12'h040, {28'h0, c[2], 2'b01, c[3]});
         if (c[1]) fw = {5'h1e, own[9:8], 1'b0, own[7:0]};
         else fw = {own[6:0] ^ {6'h0, c[0]}, 1'b0, 8'h00};
         ea = (c[3] && !c[2]) ? (c[1] ? 2'b11 : {1'b0, !c[0]}) : 2'b00;
         i_i2cta_bus_model.frame(fw, c[1] ? 2 : 1, ak);
         chk(ak, ea);
         repeat (4) @(posedge clk);
         chk(irq, m);
         chk(mst, !m);
         rd(12'h044);
         chk(rdv, {30'h0, m, 1'b0});
         wr(12'h044, 32'h3);
      end
      final_report();
   end
endmodule // test_i2c_timeout_and_slave_address
`default_nettype wire
